/* File: include/sfp_defs.svh */
// Constants of the flow-through synchronous RAM port
// How it works
// - Selected load with strobe high starts read
// - Selected load, strobe low, lane low: write
// - Continue after read presents next burst word
// - Continue during write burst writes next address
// - All lanes high on a write: no store, bus released
// - Failed select deselects until new begin
// - Clock gate high ignores the edge
// - Stall keeps read driven, never writes
// - Output enable gates read drive through a two-flop synchroniser
// - Each lane enable gates byte plus parity
// - Strobe high reads whatever lanes say
// - Order select high gives interleaved burst
// - Order select low gives linear wrap
// - States move only on rising edges
// - Sleep input high puts device asleep
// - Parity lanes carried with each byte lane
// - Sleep preserves state, resumes afterwards
`ifndef SFP_DEFS_SVH
`define SFP_DEFS_SVH
`define SFP_ADDR_W     20
`define SFP_LANES      4
`define SFP_LANE_W     9
`define SFP_DATA_W     36
`define SFP_DEPTH      1048576
`define SFP_BURST_LSB  2'h0
`define SFP_BURST_ONE  2'h1
`define SFP_CLK_NS     4
`define SFP_BUF_DEPTH  2
`endif

/* File: include/sfp_pkg.sv */
// Types of the flow-through synchronous RAM port
`include "sfp_defs.svh"
package sfp_pkg;
    // Device states, one-hot
    typedef enum logic [3:0] {
        SFP_DESEL = 4'h1,
        SFP_READ  = 4'h2,
        SFP_WRITE = 4'h4,
        SFP_BURST = 4'h8
    } sfp_state_e;
    // Pending write carried to the following edge
    typedef struct packed {
        logic [`SFP_ADDR_W-1:0] addr;
        logic [`SFP_LANES-1:0]  lane_n;
    } sfp_wreq_s;
    // Word handed from the buffer to the array
    typedef struct packed {
        logic [`SFP_ADDR_W-1:0] addr;
        logic [`SFP_LANES-1:0]  lane_n;
        logic [`SFP_DATA_W-1:0] data;
    } sfp_wword_s;
endpackage

/* File: design/sfp_buf2.sv */
// Two-entry buffer in the write data path
`timescale 1ns/10ps
`include "sfp_defs.svh"
module sfp_buf2
    import sfp_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rstn,
    // Fill side
    input  wire logic       in_valid,
    output logic            in_ready,
    input  sfp_wword_s      in_word,
    // Drain side
    output logic            out_valid,
    input  wire logic       out_ready,
    output sfp_wword_s      out_word
);
    sfp_wword_s  mem_q [`SFP_BUF_DEPTH];   // Storage
    logic        wp_q;                     // Write pointer
    logic        rp_q;                     // Read pointer
    logic [1:0]  cnt_q;                    // Occupancy
    logic        push;
    logic        pop;

    assign in_ready  = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_word  = mem_q[rp_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointers and count
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wp_q  <= 1'b0;
            rp_q  <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) wp_q <= ~wp_q;
            if (pop) rp_q <= ~rp_q;
            cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
        end
    end

    // Entry storage, no reset needed
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_q[wp_q] <= in_word;
        end
    end
endmodule

/* File: design/sfp_port.sv */
// Device side of a flow-through synchronous RAM port
`timescale 1ns/10ps
`include "sfp_defs.svh"
module sfp_port
    import sfp_pkg::*;
(
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rstn,
    // Command pins
    input  wire logic                   chip_sel_n,
    input  wire logic                   chip_sel_active_high,
    input  wire logic                   chip_sel_third_n,
    input  wire logic                   burst_continue,
    input  wire logic                   write_n,
    input  wire logic [`SFP_LANES-1:0]  lane_write_n,
    input  wire logic                   clk_gate_n,
    input  wire logic [`SFP_ADDR_W-1:0] addr,
    // Asynchronous pins
    input  wire logic                   out_enable_n,
    input  wire logic                   burst_interleave,
    input  wire logic                   sleep_request,
    // Data bus, lane n parity in bit 9n+8
    input  wire logic [`SFP_DATA_W-1:0] dq_in,
    output logic      [`SFP_DATA_W-1:0] dq_out,
    output logic                        dq_oe_n,
    // Status
    output logic                        asleep,
    output logic                        write_stall
);
    //////////////////////////////////////////////////////////////////////////
    // Storage and state
    logic [`SFP_DATA_W-1:0] ram [`SFP_DEPTH];   // Memory array
    sfp_state_e             state_q;            // Decoded command state
    logic [`SFP_ADDR_W-1:0] base_q;             // Burst start address
    logic [1:0]             step_q;             // Burst position
    logic                   rd_mode_q;          // Burst is a read
    logic                   wr_pend_q;          // Write data due next edge
    sfp_wreq_s              wreq_q;             // Pending write target
    logic [`SFP_DATA_W-1:0] rdata_q;            // Registered read word
    logic                   rd_act_q;           // Read cycle active
    logic                   mode_s1_q;          // Sync stages
    logic                   mode_s2_q;
    logic                   zz_s1_q;
    logic                   zz_s2_q;
    logic                   oe_s1_q;
    logic                   oe_s2_q;

    //////////////////////////////////////////////////////////////////////////
    // Functions
    // Burst address for a step from the start address
    function automatic logic [`SFP_ADDR_W-1:0] burst_addr(
        input logic [`SFP_ADDR_W-1:0] base,
        input logic [1:0]             step,
        input logic                   ilv);
        logic [1:0] lo;
        lo = ilv ? (base[1:0] ^ step) : 2'(base[1:0] + step);
        return {base[`SFP_ADDR_W-1:2], lo};
    endfunction

    // Byte-lane merge of new data over old
    function automatic logic [`SFP_DATA_W-1:0] lane_merge(
        input logic [`SFP_DATA_W-1:0] old_w,
        input logic [`SFP_DATA_W-1:0] new_w,
        input logic [`SFP_LANES-1:0]  lane_n);
        logic [`SFP_DATA_W-1:0] res;
        res = old_w;
        for (int i = 0; i < `SFP_LANES; i++) begin
            if (!lane_n[i]) res[i*`SFP_LANE_W +: `SFP_LANE_W] = new_w[i*`SFP_LANE_W +: `SFP_LANE_W];
        end
        return res;
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // Synchronisers for the asynchronous pins
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mode_s1_q <= 1'b0;
            mode_s2_q <= 1'b0;
            zz_s1_q   <= 1'b0;
            zz_s2_q   <= 1'b0;
            oe_s1_q   <= 1'b1;
            oe_s2_q   <= 1'b1;
        end else begin
            mode_s1_q <= burst_interleave;
            mode_s2_q <= mode_s1_q;
            zz_s1_q   <= sleep_request;
            zz_s2_q   <= zz_s1_q;
            oe_s1_q   <= out_enable_n;
            oe_s2_q   <= oe_s1_q;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Command decode
    logic sel_ok;      // All three selects asserted
    logic edge_ok;     // Edge not ignored and awake
    logic any_lane;    // At least one lane enabled
    logic new_rd;
    logic new_wr;
    logic new_ds;
    logic cont;
    logic [`SFP_ADDR_W-1:0] nxt_addr;

    assign sel_ok   = !chip_sel_n && chip_sel_active_high && !chip_sel_third_n;
    assign edge_ok  = !clk_gate_n && !zz_s2_q;
    assign any_lane = !(&lane_write_n);
    assign new_rd   = edge_ok && !burst_continue && sel_ok && write_n;
    assign new_wr   = edge_ok && !burst_continue && sel_ok && !write_n;
    assign new_ds   = edge_ok && !burst_continue && !sel_ok;
    assign cont     = edge_ok && burst_continue;
    assign nxt_addr = burst_addr(base_q, 2'(step_q + `SFP_BURST_ONE), mode_s2_q);
    assign asleep   = zz_s2_q;

    //////////////////////////////////////////////////////////////////////////
    // State machine, moves only on enabled rising edges
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= SFP_DESEL;
        end else if (edge_ok) begin
            if (new_rd) state_q <= SFP_READ;
            else if (new_wr) state_q <= SFP_WRITE;
            else if (new_ds) state_q <= SFP_DESEL;
            else state_q <= SFP_BURST;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Burst address counter and direction
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            base_q    <= '0;
            step_q    <= `SFP_BURST_LSB;
            rd_mode_q <= 1'b0;
        end else if (new_rd || new_wr) begin
            base_q    <= addr;
            step_q    <= `SFP_BURST_LSB;
            rd_mode_q <= new_rd;
        end else if (cont) begin
            step_q    <= 2'(step_q + `SFP_BURST_ONE);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Read path; data registered at the edge, driven in the same cycle
    logic rd_cycle;                 // This edge starts or continues a read
    assign rd_cycle = new_rd || (cont && rd_mode_q && state_q != SFP_DESEL &&
                                 !(state_q == SFP_BURST && !rd_act_q));
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rd_act_q <= 1'b0;
        end else if (edge_ok) begin
            rd_act_q <= rd_cycle;
        end
    end

    always_ff @(posedge core_clk) begin
        if (new_rd) rdata_q <= ram[addr];
        else if (rd_cycle) rdata_q <= ram[nxt_addr];
    end

    // Drive only in a read cycle with output enable low
    assign dq_out  = rdata_q;
    assign dq_oe_n = !(rd_act_q && !oe_s2_q);

    //////////////////////////////////////////////////////////////////////////
    // Write path; address captured now, data taken at next edge
    logic wr_cont;
    assign wr_cont = cont && !rd_mode_q && (state_q == SFP_WRITE ||
                     (state_q == SFP_BURST && wr_pend_q)) ;
    logic wr_seen;                  // Write-type cycle, even if aborted
    assign wr_seen = new_wr || wr_cont;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wr_pend_q <= 1'b0;
            wreq_q    <= '0;
        end else if (edge_ok) begin
            wr_pend_q     <= wr_seen;
            wreq_q.addr   <= new_wr ? addr : nxt_addr;
            wreq_q.lane_n <= any_lane ? lane_write_n : '1;
        end
    end

    // Buffer between bus capture and array update
    sfp_wword_s buf_in;
    sfp_wword_s buf_out;
    logic       buf_in_v;
    logic       buf_in_rdy;
    logic       buf_out_v;
    logic       buf_out_rdy;
    assign buf_in.addr   = wreq_q.addr;
    assign buf_in.lane_n = wreq_q.lane_n;
    assign buf_in.data   = dq_in;
    assign buf_in_v      = wr_pend_q && edge_ok && !(&wreq_q.lane_n);
    assign buf_out_rdy   = !rd_cycle;       // Array port busy with reads
    assign write_stall   = wr_pend_q && !buf_in_rdy;

    sfp_buf2 u_buf (
        .core_clk  (core_clk),
        .rstn      (rstn),
        .in_valid  (buf_in_v),
        .in_ready  (buf_in_rdy),
        .in_word   (buf_in),
        .out_valid (buf_out_v),
        .out_ready (buf_out_rdy),
        .out_word  (buf_out)
    );

    // Array update
    always_ff @(posedge core_clk) begin
        if (buf_out_v && buf_out_rdy) begin
            ram[buf_out.addr] <= lane_merge(ram[buf_out.addr], buf_out.data, buf_out.lane_n);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Assertions
    a_bus_off_write: assert property (@(posedge core_clk) disable iff (!rstn)
        wr_pend_q |-> dq_oe_n) else $error("bus driven in write");
    a_stall_holds: assert property (@(posedge core_clk) disable iff (!rstn)
        (clk_gate_n && !zz_s2_q) |=> $stable(state_q) && $stable(step_q)) else $error("stall moved state");
    a_stall_no_write: assert property (@(posedge core_clk) disable iff (!rstn)
        !edge_ok |-> !buf_in_v) else $error("write on stalled edge");
    a_read_drive: assert property (@(posedge core_clk) disable iff (!rstn)
        new_rd ##1 !oe_s2_q |-> !dq_oe_n) else $error("read not driven");
    a_desel_quiet: assert property (@(posedge core_clk) disable iff (!rstn)
        new_ds |=> dq_oe_n) else $error("deselect drove bus");
    a_burst_step: assert property (@(posedge core_clk) disable iff (!rstn)
        (cont && !new_rd) |=> step_q == 2'($past(step_q) + 2'h1)) else $error("burst did not step");
    a_new_base: assert property (@(posedge core_clk) disable iff (!rstn)
        new_wr |=> base_q == $past(addr) && step_q == 2'h0) else $error("write base wrong");
    a_sleep_frozen: assert property (@(posedge core_clk) disable iff (!rstn)
        zz_s2_q |=> $stable(state_q)) else $error("state moved asleep");
    c_read_burst: cover property (@(posedge core_clk) disable iff (!rstn) new_rd ##1 cont ##1 cont);
    c_write_burst: cover property (@(posedge core_clk) disable iff (!rstn) new_wr ##1 cont);
    c_stall_read: cover property (@(posedge core_clk) disable iff (!rstn) rd_act_q && clk_gate_n);
endmodule

/* File: dv/sfp_host.sv */
// Host memory controller model that drives the port's pins
`timescale 1ns/10ps
`include "sfp_defs.svh"
module sfp_host (
    // Clock
    input  wire logic                   core_clk,
    // Command pins, sel is {first_n, active_high, third_n}
    output logic [2:0]                  sel,
    output logic                        cont,
    output logic                        wr_n,
    output logic [`SFP_LANES-1:0]       lanes_n,
    output logic                        gate_n,
    output logic [`SFP_ADDR_W-1:0]      addr,
    // Slow pins and write data
    output logic                        oe_n,
    output logic                        ilv,
    output logic                        sleep,
    output logic [`SFP_DATA_W-1:0]      dq
);
    logic                  pend;   // Write data owed at the next edge
    logic [`SFP_DATA_W-1:0] pend_d; // The data owed

    // Idle pins at time zero
    initial begin
        sel = 3'h6;
        {cont, wr_n, lanes_n, gate_n, addr} = {1'h0, 1'h1, 4'hF, 1'h0, 20'h0};
        {oe_n, ilv, sleep, pend, dq, pend_d} = {3'h4, 1'h0, 72'h0};
    end

    // One command at the next edge; its write data follows one edge later
    task automatic cyc(input logic [2:0] s, input logic c, w, input logic [3:0] l,
                       input logic [19:0] a, input logic [35:0] d, input logic g);
        @(negedge core_clk);
        if (!g) begin
            dq = pend ? pend_d : ~dq;
            pend = ~w;
            pend_d = d;
        end
        {sel, cont, wr_n, lanes_n, addr, gate_n} = {s, c, w, l, a, g};
        @(posedge core_clk);
        #1;
    endtask

    // Slow pins change only while the port idles
    task automatic set(input logic o, i, z);
        cyc(3'h6, 1'h0, 1'h1, 4'hF, 20'h0, 36'h0, 1'h0);
        @(negedge core_clk);
        {oe_n, ilv, sleep} = {o, i, z};
        repeat (3) cyc(3'h6, 1'h0, 1'h1, 4'hF, 20'h0, 36'h0, 1'h0);
    endtask
endmodule

/* File: dv/sfp_port_bench.sv */
// Self-checking bench for the flow-through RAM port
`timescale 1ns/10ps
`include "sfp_defs.svh"
module sfp_port_bench;
    logic        core_clk, rstn, cont, wr_n, gate_n, oe_n, ilv, sleep; // Pins
    logic [2:0]  sel;          // Selects
    logic [3:0]  lanes_n;      // Lane enables
    logic [19:0] addr;         // Address
    logic [35:0] dq, dq_out;   // Data both ways
    logic        dq_oe_n, asleep, write_stall; // Status
    logic [35:0] mem [int];    // Expected array contents
    int          miscompares, tests_run;

    sfp_host host (.core_clk(core_clk), .sel(sel), .cont(cont), .wr_n(wr_n), .lanes_n(lanes_n),
        .gate_n(gate_n), .addr(addr), .oe_n(oe_n), .ilv(ilv), .sleep(sleep), .dq(dq));
    sfp_port dut (.core_clk(core_clk), .rstn(rstn), .chip_sel_n(sel[2]), .chip_sel_active_high(sel[1]),
        .chip_sel_third_n(sel[0]), .burst_continue(cont), .write_n(wr_n), .lane_write_n(lanes_n),
        .clk_gate_n(gate_n), .addr(addr), .out_enable_n(oe_n), .burst_interleave(ilv),
        .sleep_request(sleep), .dq_in(dq), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .asleep(asleep),
        .write_stall(write_stall));

    // Clock at 4 ns
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic check(input string n, input logic [35:0] s, e);
        tests_run++;
        if (s !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) host.cyc(3'h6, 1'h0, 1'h1, 4'hF, 20'h0, 36'h0, 1'h0);
    endtask
    // Single write, merging enabled lanes into the expected array
    task automatic wr1(input logic [19:0] a, input logic [35:0] d, input logic [3:0] l);
        host.cyc(3'h2, 1'h0, 1'h0, l, a, d, 1'h0);
        for (int i = 0; i < 4; i++) if (!l[i]) mem[a][9*i+:9] = d[9*i+:9];
    endtask
    // Single read with lanes low still reads
    task automatic rd1(input logic [19:0] a);
        host.cyc(3'h2, 1'h0, 1'h1, 4'h0, a, 36'h0, 1'h0);
        check("read data", dq_out, mem[a]);
        check("read drive", dq_oe_n, 1'b0);
    endtask
    function automatic logic [19:0] nxt(input logic [19:0] b, input logic [1:0] lo, st, input logic m);
        nxt = {b[19:2], m ? lo ^ st : lo + st};
    endfunction
    task automatic wait_sleep(input logic v);
        for (int i = 0; i < 10 && asleep !== v; i++) idle(1);
        check("asleep", asleep, v);
        if (asleep !== v) complete_run();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_lanes();
        wr1(20'h00010, 36'hA5A5A5A5A, 4'h0);
        idle(4);
        rd1(20'h00010);
        wr1(20'h00010, 36'h123456789, 4'hF);
        check("abort drive", dq_oe_n, 1'b1);
        for (int i = 0; i < 4; i++) wr1(20'h00010, 36'h3C3C3C3C3 + i, ~(4'h1 << i));
        idle(4);
        rd1(20'h00010);
        $display("test lanes done");
    endtask
    task automatic t_burst();
        logic [35:0] hold;
        for (int m = 0; m < 2; m++) begin
            host.set(1'b0, m[0], 1'b0);
            for (int b = 0; b < 4; b++) begin
                if (b == 0) wr1(20'h00200, 36'h0F0F0F000 + m * 16, 4'h0);
                else host.cyc(3'h6, 1'h1, 1'h0, 4'h0, 20'hFFFFF, 36'h0F0F0F000 + m * 16 + b, 1'h0);
                mem[nxt(20'h00200, 2'h0, b[1:0], m[0])] = 36'h0F0F0F000 + m * 16 + b;
            end
            idle(4);
            for (int b = 0; b < 4; b++) begin
                host.cyc(b ? 3'h6 : 3'h2, b != 0, 1'h1, 4'hF, b ? 20'hFFFFF : 20'h00201, 36'h0, 1'h0);
                check("burst data", dq_out, mem[nxt(20'h00200, 2'h1, b[1:0], m[0])]);
                hold = dq_out;
                host.cyc(3'h6, 1'h0, 1'h0, 4'h0, 20'h0, 36'h0, 1'h1);
                check("stall data", dq_out, hold);
                check("stall drive", dq_oe_n, 1'b0);
            end
        end
        $display("test burst done");
    endtask
    task automatic t_desel();
        logic [2:0] pat [3] = '{3'h6, 3'h0, 3'h3};
        foreach (pat[k]) begin
            rd1(20'h00010);
            host.cyc(pat[k], 1'h0, 1'h1, 4'hF, 20'h00010, 36'h0, 1'h0);
            check("deselect drive", dq_oe_n, 1'b1);
            host.cyc(3'h2, 1'h1, 1'h1, 4'hF, 20'h00010, 36'h0, 1'h0);
            check("continue deselect", dq_oe_n, 1'b1);
        end
        host.set(1'b1, 1'b1, 1'b0);
        host.cyc(3'h2, 1'h0, 1'h1, 4'hF, 20'h00010, 36'h0, 1'h0);
        check("disabled drive", dq_oe_n, 1'b1);
        host.set(1'b0, 1'b1, 1'b0);
        $display("test deselect done");
    endtask
    task automatic t_sleep();
        host.set(1'b0, 1'b1, 1'b1);
        wait_sleep(1'b1);
        host.cyc(3'h2, 1'h0, 1'h0, 4'h0, 20'h00010, 36'h777777777, 1'h0);
        host.set(1'b0, 1'b1, 1'b0);
        wait_sleep(1'b0);
        rd1(20'h00010);
        $display("test sleep done");
    endtask
    task automatic t_buffer();
        for (int i = 0; i < 3; i++) begin
            wr1(20'h00020 + i, 36'h9E9E9E9E0 + i, 4'h0);
            rd1(20'h00010);
        end
        idle(6);
        check("stall flag", write_stall, 1'b0);
        for (int i = 0; i < 3; i++) rd1(20'h00020 + i);
        $display("test buffer done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial begin
        rstn = 1'b0;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        rstn = 1'b1;
        host.set(1'b0, 1'b0, 1'b0);
        t_lanes();
        t_burst();
        t_desel();
        t_sleep();
        t_buffer();
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        check("watchdog", 36'h1, 36'h0);
        complete_run();
    end
endmodule
